//--- include/mia_pkg.sv
// Package for the motion I/O and host write-privilege block
package mia_pkg;
    // ------------------------------------------------------------
    // Register byte offsets on APB
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DISCRETE_INPUT_WORD = 8'h00;
    localparam logic [7:0] ADDR_DISCRETE_OUTPUT_WORD = 8'h04;
    localparam logic [7:0] ADDR_INPUT_USAGE = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_HOST_COMMAND = 8'h14;
    localparam logic [7:0] ADDR_SERIAL_CONFIG = 8'h18;
    localparam logic [7:0] ADDR_AUX_DATA = 8'h1c;

    // ------------------------------------------------------------
    // Discrete input and output word bit positions
    // ------------------------------------------------------------
    localparam int BIT_POS_LIMIT_OK = 0;
    localparam int BIT_NEG_LIMIT_OK = 1;
    localparam int BIT_NOT_HOME = 2;
    localparam int BIT_JOG_POS = 3;
    localparam int BIT_DRIVE_FAULT = 4;
    localparam int BIT_BRAKE = 0;

    // Inputs 1..3 predefined, 4..5 general at power-up
    localparam logic [4:0] INPUT_USAGE_RESET = 5'h07;
    localparam int NUM_INPUTS = 5;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_DRIVE_ENABLE = 0;
    localparam int CTL_DC_DRIVE = 1;
    localparam int CTL_AUX_USER = 2;

    // ------------------------------------------------------------
    // Host command register fields
    // ------------------------------------------------------------
    localparam int CMD_HOST_BIT = 0;
    localparam int CMD_WRITE_CLASS = 1;
    localparam int CMD_LOG_READ = 2;
    localparam int CMD_LOCKOUT = 3;
    localparam int CMD_LOCKOUT_CLEAR = 4;

    // ------------------------------------------------------------
    // Serial defaults when the setup switch is closed
    // ------------------------------------------------------------
    localparam logic [3:0] SER_DATA_BITS_DEFAULT = 4'h7;
    localparam logic [1:0] SER_PARITY_EVEN = 2'h1;
    localparam logic [1:0] SER_STOP_BITS_DEFAULT = 2'h1;
    localparam logic [15:0] SER_BAUD_DEFAULT = 16'h2580;
    localparam logic [31:0] SER_CONFIG_DEFAULT =
        {8'h00, SER_BAUD_DEFAULT, SER_STOP_BITS_DEFAULT, SER_PARITY_EVEN, SER_DATA_BITS_DEFAULT};
    localparam logic [31:0] AUX_DATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Power-up sampling sequence
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PU_WAIT = 2'b00,
        PU_SAMPLE = 2'b01,
        PU_RUN = 2'b11
    } mia_pu_e;

    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_CONTROLLER = 2'b01,
        OWN_SETUP_TOOL = 2'b10
    } mia_owner_e;
endpackage : mia_pkg

//--- rtl/mia_motion_io.sv
// Discrete I/O, drive status and host write-privilege arbiter, APB slave
//
// Overview of operation
// - five discrete inputs, one discrete output
// - each input has a general/predefined usage bit; input word takes raw pins
// - inputs 1-3 predefined, 4-5 general at reset
// - input word flags fault, jog, home, limits
// - output word bit sets brake released
// - high fault line means drive fault
// - drive enable output drives relay contact
// - three phase commands, dc uses A and C
// - over-temperature shown as fault plus own indicator
// - open thermal input means over-temperature
// - aux analog output source selected by setup
// - one or two encoders accepted
// - mode switch sampled once at power-up
// - serial switch sampled at power-up
// - setup tool alone gets write privilege unless local lockout is set
// - controller alone gets write privilege
// - local lockout gives controller write privilege
// - both active, mode switch picks writer unless local lockout is set
// - reads allowed from either host always
// - error-log read needs write privilege
// - serial default 7E1 at 9600 baud
// - serial changes only with switch open
module mia_motion_io
    import mia_pkg::*;
#(
    parameter int CMD_WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Discrete field pins
    input wire logic [4:0] fieldInput,
    output logic brakeOutput,
    // Drive interface
    input wire logic driveFaultLine,
    input wire logic thermalOpen,
    output logic driveEnable,
    output logic driveFaultLed,
    output logic motorOverTempLed,
    // Phase current commands
    input wire logic signed [CMD_WIDTH-1:0] phaseCmdA,
    input wire logic signed [CMD_WIDTH-1:0] phaseCmdB,
    input wire logic signed [CMD_WIDTH-1:0] phaseCmdC,
    output logic signed [CMD_WIDTH-1:0] phaseOutA,
    output logic signed [CMD_WIDTH-1:0] phaseOutB,
    output logic signed [CMD_WIDTH-1:0] phaseOutC,
    // Auxiliary analog output
    input wire logic [CMD_WIDTH-1:0] auxDiagValue,
    output logic [CMD_WIDTH-1:0] auxOutput,
    // Encoders
    input wire logic encoder1Present,
    input wire logic encoder2Present,
    output logic [1:0] encoderCount,
    // Host activity and switches
    input wire logic controllerActive,
    input wire logic setupToolAttached,
    input wire logic operatingModeSwitchClosed,
    input wire logic serialSetupSwitchClosed,
    output logic controllerMayWrite,
    output logic setupToolMayWrite,
    output logic [31:0] serialConfig,
    output logic errorLogClear
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mia_pu_e puState;
        logic modeSwitchClosed;
        logic serialSwitchClosed;
        logic localLockout;
        logic [4:0] inputUsage;
        logic [15:0] discreteOutputWord;
        logic [15:0] discreteInputWord;
        logic [2:0] control;
        logic [31:0] serialCfg;
        logic [31:0] auxData;
        logic [31:0] rdata;
        logic slverr;
        logic refused;
        logic logClear;
        logic signed [CMD_WIDTH-1:0] phA;
        logic signed [CMD_WIDTH-1:0] phB;
        logic signed [CMD_WIDTH-1:0] phC;
        logic [CMD_WIDTH-1:0] aux;
    } mia_state_s;

    mia_state_s st;
    mia_state_s next_st;

    // ------------------------------------------------------------
    // Write privilege decode
    // ------------------------------------------------------------
    function automatic mia_owner_e priv_owner(input logic ctl, input logic tool,
                                              input logic lockout, input logic modeClosed);
        if (lockout) begin
            priv_owner = OWN_CONTROLLER;
        end else if (ctl && tool) begin
            priv_owner = modeClosed ? OWN_SETUP_TOOL : OWN_CONTROLLER;
        end else if (tool) begin
            priv_owner = OWN_SETUP_TOOL;
        end else if (ctl) begin
            priv_owner = OWN_CONTROLLER;
        end else begin
            priv_owner = OWN_NONE;
        end
    endfunction : priv_owner

    mia_owner_e owner;
    logic access;
    logic wrAccess;
    logic hostIsTool;
    logic hostMayWrite;
    logic cmdRefused;
    logic overTemp;
    logic driveFault;
    logic [4:0] effInput;

    // Combinational so privilege follows activity the same cycle
    assign owner = priv_owner(controllerActive, setupToolAttached, st.localLockout,
                              st.modeSwitchClosed);
    assign access = psel && penable;
    assign wrAccess = access && pwrite;
    assign hostIsTool = pwdata[CMD_HOST_BIT];
    assign hostMayWrite = hostIsTool ? (owner == OWN_SETUP_TOOL) : (owner == OWN_CONTROLLER);
    // Lockout set or clear from the controller is never refused
    assign cmdRefused = pwrite && (paddr == ADDR_HOST_COMMAND)
                        && !((pwdata[CMD_LOCKOUT] || pwdata[CMD_LOCKOUT_CLEAR]) && !hostIsTool)
                        && (pwdata[CMD_WRITE_CLASS] || pwdata[CMD_LOG_READ])
                        && !hostMayWrite;
    assign overTemp = thermalOpen;
    assign driveFault = driveFaultLine || overTemp;

    // Every input passes raw whether predefined or general; inputUsage does not change effInput
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
        assign effInput[i] = fieldInput[i];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.refused = 1'b0;
        next_st.logClear = 1'b0;
        next_st.slverr = 1'b0;
        case (st.puState)
            PU_WAIT: begin
                next_st.puState = PU_SAMPLE;
            end
            PU_SAMPLE: begin
                // Switches caught once after reset release, never again
                next_st.modeSwitchClosed = operatingModeSwitchClosed;
                next_st.serialSwitchClosed = serialSetupSwitchClosed;
                if (serialSetupSwitchClosed) begin
                    next_st.serialCfg = SER_CONFIG_DEFAULT;
                end
                next_st.puState = PU_RUN;
            end
            default: begin
                next_st.puState = PU_RUN;
            end
        endcase

        next_st.discreteInputWord = 16'h0000;
        next_st.discreteInputWord[BIT_POS_LIMIT_OK] = effInput[0];
        next_st.discreteInputWord[BIT_NEG_LIMIT_OK] = effInput[1];
        next_st.discreteInputWord[BIT_NOT_HOME] = effInput[2];
        next_st.discreteInputWord[BIT_JOG_POS] = effInput[3];
        next_st.discreteInputWord[BIT_DRIVE_FAULT] = driveFault;

        next_st.phA = phaseCmdA;
        next_st.phB = st.control[CTL_DC_DRIVE] ? '0 : phaseCmdB;
        next_st.phC = phaseCmdC;
        next_st.aux = st.control[CTL_AUX_USER] ? st.auxData[CMD_WIDTH-1:0] : auxDiagValue;

        if (psel && !penable && !pwrite) begin
            // Reads never depend on privilege
            if (paddr == ADDR_DISCRETE_INPUT_WORD) begin
                next_st.rdata = {16'h0000, st.discreteInputWord};
            end else if (paddr == ADDR_DISCRETE_OUTPUT_WORD) begin
                next_st.rdata = {16'h0000, st.discreteOutputWord};
            end else if (paddr == ADDR_INPUT_USAGE) begin
                next_st.rdata = {27'h0000000, st.inputUsage};
            end else if (paddr == ADDR_CONTROL) begin
                next_st.rdata = {29'h00000000, st.control};
            end else if (paddr == ADDR_STATUS) begin
                next_st.rdata = {24'h000000, st.serialSwitchClosed, st.modeSwitchClosed,
                                 st.localLockout, owner, encoder2Present, overTemp, driveFault};
            end else if (paddr == ADDR_SERIAL_CONFIG) begin
                next_st.rdata = st.serialCfg;
            end else if (paddr == ADDR_AUX_DATA) begin
                next_st.rdata = st.auxData;
            end else if (paddr == ADDR_HOST_COMMAND) begin
                next_st.rdata = {31'h00000000, st.refused};
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end

        // Error decided at the setup edge so it stands through the access cycle
        if (psel && !penable) begin
            if (!(paddr == ADDR_DISCRETE_INPUT_WORD || paddr == ADDR_DISCRETE_OUTPUT_WORD ||
                  paddr == ADDR_INPUT_USAGE || paddr == ADDR_CONTROL ||
                  paddr == ADDR_STATUS || paddr == ADDR_HOST_COMMAND ||
                  paddr == ADDR_SERIAL_CONFIG || paddr == ADDR_AUX_DATA)) begin
                next_st.slverr = 1'b1;
            end else if (cmdRefused) begin
                next_st.slverr = 1'b1;
            end
        end

        if (wrAccess) begin
            if (paddr == ADDR_HOST_COMMAND) begin
                // Host tags each command; write-class ones need privilege
                if (pwdata[CMD_LOCKOUT] && !hostIsTool) begin
                    next_st.localLockout = 1'b1;
                end else if (pwdata[CMD_LOCKOUT_CLEAR] && !hostIsTool) begin
                    next_st.localLockout = 1'b0;
                end else if ((pwdata[CMD_WRITE_CLASS] || pwdata[CMD_LOG_READ])
                             && !hostMayWrite) begin
                    next_st.refused = 1'b1;
                end else if (pwdata[CMD_LOG_READ]) begin
                    next_st.logClear = 1'b1;
                end
            end else if (paddr == ADDR_DISCRETE_OUTPUT_WORD) begin
                next_st.discreteOutputWord = pwdata[15:0];
            end else if (paddr == ADDR_INPUT_USAGE) begin
                next_st.inputUsage = pwdata[4:0];
            end else if (paddr == ADDR_CONTROL) begin
                next_st.control = pwdata[2:0];
            end else if (paddr == ADDR_SERIAL_CONFIG) begin
                if (!st.serialSwitchClosed) begin
                    next_st.serialCfg = pwdata;
                end
            end else if (paddr == ADDR_AUX_DATA) begin
                next_st.auxData = pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.puState <= PU_WAIT;
            st.inputUsage <= INPUT_USAGE_RESET;
            st.serialCfg <= SER_CONFIG_DEFAULT;
            st.auxData <= AUX_DATA_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = st.slverr;
    assign brakeOutput = st.discreteOutputWord[BIT_BRAKE];
    assign driveEnable = st.control[CTL_DRIVE_ENABLE];
    assign driveFaultLed = st.discreteInputWord[BIT_DRIVE_FAULT];
    assign motorOverTempLed = overTemp;
    assign phaseOutA = st.phA;
    assign phaseOutB = st.phB;
    assign phaseOutC = st.phC;
    assign auxOutput = st.aux;
    assign encoderCount = {1'b0, encoder1Present} + {1'b0, encoder2Present};
    assign controllerMayWrite = (owner == OWN_CONTROLLER);
    assign setupToolMayWrite = (owner == OWN_SETUP_TOOL);
    assign serialConfig = st.serialCfg;
    assign errorLogClear = st.logClear;

endmodule : mia_motion_io

//--- bench/mia_motion_io_checker.sv
// Port-level assertions for the motion I/O block
module mia_motion_io_checker
    import mia_pkg::*;
(
    // Clock, reset and APB
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic brakeOutput,
    input wire logic driveFaultLine,
    input wire logic thermalOpen,
    input wire logic driveFaultLed,
    input wire logic motorOverTempLed,
    input wire logic encoder1Present,
    input wire logic encoder2Present,
    input wire logic [1:0] encoderCount,
    input wire logic controllerActive,
    input wire logic setupToolAttached,
    input wire logic controllerMayWrite,
    input wire logic setupToolMayWrite,
    input wire logic errorLogClear
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic acc;
    logic logReq;
    assign acc = psel && penable && pready;
    assign logReq = acc && pwrite && paddr == ADDR_HOST_COMMAND && pwdata[CMD_LOG_READ];

    a_temp_lamp: assert property (motorOverTempLed == thermalOpen)
        else $error("overtemp lamp differs from thermal input");
    a_fault_lamp: assert property ($past(reset_n) |->
        driveFaultLed == ($past(driveFaultLine) || $past(thermalOpen)))
        else $error("fault lamp not fault or overtemp");
    a_one_writer: assert property (!(controllerMayWrite && setupToolMayWrite))
        else $error("two hosts hold write privilege");
    a_ctl_alone: assert property (controllerActive && !setupToolAttached |-> controllerMayWrite)
        else $error("lone controller lacks privilege");
    a_enc_count: assert property (encoderCount == {1'b0, encoder1Present} + {1'b0, encoder2Present})
        else $error("encoder count wrong");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access not answered at once");
    a_brake_write: assert property (acc && pwrite && paddr == ADDR_DISCRETE_OUTPUT_WORD |=>
        brakeOutput == $past(pwdata[BIT_BRAKE]))
        else $error("brake output not from written word");
    a_log_cause: assert property (errorLogClear |-> $past(logReq))
        else $error("log cleared without log read");
    a_log_refused: assert property (logReq && !(pwdata[CMD_HOST_BIT] ? setupToolMayWrite :
        controllerMayWrite) |-> pslverr ##1 !errorLogClear)
        else $error("unprivileged log read accepted");

    c_refused: cover property (acc && pslverr);
    c_log_clear: cover property (errorLogClear);
    c_tool_wins: cover property (controllerActive && setupToolAttached && setupToolMayWrite);
endmodule : mia_motion_io_checker

bind mia_motion_io mia_motion_io_checker u_chk (.*);

//--- bench/mia_far_model.sv
// Behavioural model of the two hosts' activity and of the drive side
module mia_far_model (
    // Clock
    input wire logic clk,
    // Scenario controls
    input wire logic wantController,
    input wire logic wantTool,
    input wire logic driveFailed,
    input wire logic sensorOpen,
    // Lines into the block
    output logic controllerActive,
    output logic setupToolAttached,
    output logic driveFaultLine,
    output logic thermalOpen
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        controllerActive = 1'b0;
        setupToolAttached = 1'b0;
        driveFaultLine = 1'b0;
        thermalOpen = 1'b0;
    end
    // Healthy drive grounds its line; unused sensor input counts as shorted
    always @(posedge clk) begin
        controllerActive <= wantController;
        setupToolAttached <= wantTool;
        driveFaultLine <= driveFailed;
        thermalOpen <= sensorOpen;
    end
endmodule : mia_far_model

//--- bench/mia_motion_io_tb_top.sv
// Self-checking testbench for the motion I/O block
module mia_motion_io_tb_top;
    import mia_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, brakeOutput;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, serialConfig, rd;
    logic [4:0] fieldInput;
    logic driveFaultLine, thermalOpen, driveEnable, driveFaultLed, motorOverTempLed;
    logic signed [15:0] phaseCmdA, phaseCmdB, phaseCmdC, phaseOutA, phaseOutB, phaseOutC;
    logic [15:0] auxDiagValue, auxOutput;
    logic encoder1Present, encoder2Present, errorLogClear, er;
    logic [1:0] encoderCount;
    logic controllerActive, setupToolAttached, controllerMayWrite, setupToolMayWrite;
    logic operatingModeSwitchClosed, serialSetupSwitchClosed;
    logic wantController, wantTool, driveFailed, sensorOpen;
    int fails = 0;
    int checks_done = 0;

    mia_motion_io dut (.*);
    mia_far_model far (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32
    task automatic chkbit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkbit
    // Holds the request until pready is seen at an edge, then releases it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic do_reset(input logic mode, input logic ser);
        reset_n <= 1'b0;
        operatingModeSwitchClosed <= mode;
        serialSetupSwitchClosed <= ser;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset
    task automatic priv(input logic c, input logic t, input logic ec, input logic et);
        @(posedge clk);
        wantController <= c;
        wantTool <= t;
        repeat (3) @(posedge clk);
        #1;
        chkbit(controllerMayWrite, ec);
        chkbit(setupToolMayWrite, et);
    endtask : priv

    initial begin
        #100000;
        fails++;
        print_verdict();
    end
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {wantController, wantTool, driveFailed, sensorOpen} = '0;
        {operatingModeSwitchClosed, serialSetupSwitchClosed} = '0;
        {encoder1Present, encoder2Present, fieldInput} = '0;
        phaseCmdA = 16'h0111;
        phaseCmdB = 16'h0123;
        phaseCmdC = 16'h0333;
        auxDiagValue = 16'h0abc;
        do_reset(1'b0, 1'b1);
        apb(1'b0, ADDR_INPUT_USAGE, 32'h0);
        chk32(rd, {27'h0, INPUT_USAGE_RESET});
        chk32(serialConfig, SER_CONFIG_DEFAULT);
        apb(1'b1, ADDR_SERIAL_CONFIG, 32'h0000_1234);
        chk32(serialConfig, SER_CONFIG_DEFAULT);
        apb(1'b0, 8'h40, 32'h0);
        chkbit(er, 1'b1);
        fieldInput <= 5'h1a;
        driveFailed <= 1'b1;
        encoder1Present <= 1'b1;
        encoder2Present <= 1'b1;
        apb(1'b0, ADDR_DISCRETE_INPUT_WORD, 32'h0);
        apb(1'b0, ADDR_DISCRETE_INPUT_WORD, 32'h0);
        chk32(rd, 32'h0000_001a);
        chkbit(driveFaultLed, 1'b1);
        chk32({30'h0, encoderCount}, 32'h2);
        driveFailed <= 1'b0;
        apb(1'b1, ADDR_DISCRETE_OUTPUT_WORD, 32'h1);
        chkbit(brakeOutput, 1'b1);
        apb(1'b1, ADDR_AUX_DATA, 32'h0000_5555);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_CONTROL, 32'h1 << i);
            repeat (2) @(posedge clk);
            #1;
            chkbit(driveEnable, i == 0);
            chk32(32'(phaseOutB), (i == 1) ? 32'h0 : 32'h0123);
            chk32({16'h0, auxOutput}, (i == 2) ? 32'h5555 : 32'h0abc);
        end
        sensorOpen <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chkbit(motorOverTempLed, 1'b1);
        chkbit(driveFaultLed, 1'b1);
        chkbit(rd[1], 1'b1);
        sensorOpen <= 1'b0;
        priv(1'b0, 1'b1, 1'b0, 1'b1);
        priv(1'b1, 1'b0, 1'b1, 1'b0);
        priv(1'b1, 1'b1, 1'b1, 1'b0);
        apb(1'b1, ADDR_HOST_COMMAND, 32'h5);
        chkbit(er, 1'b1);
        chkbit(errorLogClear, 1'b0);
        apb(1'b1, ADDR_HOST_COMMAND, 32'h4);
        chkbit(er, 1'b0);
        chkbit(errorLogClear, 1'b1);
        do_reset(1'b1, 1'b0);
        operatingModeSwitchClosed <= 1'b0;
        priv(1'b1, 1'b1, 1'b0, 1'b1);
        apb(1'b1, ADDR_HOST_COMMAND, 32'h8);
        priv(1'b1, 1'b1, 1'b1, 1'b0);
        apb(1'b1, ADDR_HOST_COMMAND, 32'h10);
        priv(1'b1, 1'b1, 1'b0, 1'b1);
        apb(1'b1, ADDR_SERIAL_CONFIG, 32'h0000_1234);
        chk32(serialConfig, 32'h0000_1234);
        print_verdict();
    end
endmodule : mia_motion_io_tb_top
